//--- dai_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module dai_bus_model (
    // Clock, reset and bench commands
    input wire logic clk_sys, sys_rst, go, slow,
    // Transfer events towards the channel, and busy back to the bench
    output logic     read_done, write_start, write_done, busy
);
    logic [2:0] st;
    // Slow mode adds a wait state between read and write, as a busy memory would.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) st <= 3'h0;
        else if (st == 3'h0) st <= go ? 3'h1 : 3'h0;
        else if (st == 3'h4) st <= 3'h0;
        else if (st == 3'h1 && !slow) st <= 3'h3;
        else st <= st + 3'h1;
    end
    assign read_done   = st == 3'h1;
    assign write_start = st == 3'h3;
    assign write_done  = st == 3'h4;
    assign busy        = st != 3'h0;
endmodule : dai_bus_model
`default_nettype wire

//--- dai_channel.sv
`timescale 1ns/1ps
`default_nettype none
module dai_channel #(
    parameter bit TWO_CHANNEL = 1'b0
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // Register loads from the CPU side
    input  wire logic [31:0] reg_wdata,
    input  wire logic        source_load,
    input  wire logic        dest_load,
    input  wire logic        count_load,
    input  wire logic        gate_load,
    // Channel control bits
    input  wire logic        source_step_up,
    input  wire logic        source_step_down,
    input  wire logic        dest_step_up,
    input  wire logic        dest_step_down,
    input  wire logic        count_zero_irq_on,
    // Transfer events
    input  wire logic        read_done,
    input  wire logic        write_start,
    input  wire logic        write_done,
    input  wire logic        dma_irq_clear,
    // Interrupt sources
    input  wire logic [3:0]  ext_irq,
    input  wire logic        serial0_tx_irq,
    input  wire logic        serial0_rx_irq,
    input  wire logic        serial1_tx_irq,
    input  wire logic        serial1_rx_irq,
    input  wire logic        timer0_irq,
    input  wire logic        timer1_irq,
    input  wire logic        peer_dma_done,
    // Register contents
    output logic [23:0]      dma_source_pointer,
    output logic [23:0]      dma_destination_pointer,
    output logic [23:0]      dma_word_countdown,
    output logic [31:0]      cpu_dma_interrupt_gate,
    // Status
    output logic             dma_irq_flag,
    output logic             count_at_zero,
    // Gated interrupt outputs
    output logic [11:0]      cpu_irq_gated,
    output logic [11:0]      dma0_sync_gated,
    output logic [11:0]      dma1_sync_gated
);

    ////////////////////////////////////////////////////////////////////////////////////////////

    typedef enum logic [1:0] {
        ph_idle       = 2'b01,
        ph_last_write = 2'b10
    } dai_phase_type;

    typedef struct packed {
        logic [23:0]   src;
        logic [23:0]   dst;
        logic [23:0]   cnt;
        logic [31:0]   gate;
        dai_phase_type phase;
        logic          flag;
        logic          zero;
        logic [11:0]   cpu_out;
        logic [11:0]   dma0_out;
        logic [11:0]   dma1_out;
    } dai_state_type;

    dai_state_type state;
    dai_state_type next_state;

    logic [11:0] source_vec;
    logic [11:0] cpu_pass;
    logic [11:0] dma0_pass;
    logic [11:0] dma1_pass;
    logic [23:0] count_less;

    localparam logic [31:0] GATE_WMASK =
        TWO_CHANNEL ? dai_pkg::GATE_WMASK_TWO : dai_pkg::GATE_WMASK_ONE;

    ////////////////////////////////////////////////////////////////////////////////////////////

    // Both step bits set is taken as hold, so a half-written control word never moves
    // the pointer in a surprising direction. Natural 24-bit arithmetic gives the wrap.
    function automatic logic [23:0] dai_step(
        input logic [23:0] cur,
        input logic        up,
        input logic        down
    );
        logic [23:0] res;
        res = cur;
        if (up && !down) begin
            res = cur + dai_pkg::COUNT_ONE;
        end else if (down && !up) begin
            res = cur - dai_pkg::COUNT_ONE;
        end
        return res;
    endfunction : dai_step

    ////////////////////////////////////////////////////////////////////////////////////////////

    // Source order shared by the CPU view and both DMA views. The channel's own flag
    // is the DMA 0 completion source, so gating it adds one cycle on top of the flag.
    assign source_vec[3:0] = ext_irq;
    assign source_vec[4]   = serial0_tx_irq;
    assign source_vec[5]   = serial0_rx_irq;
    assign source_vec[6]   = serial1_tx_irq;
    assign source_vec[7]   = serial1_rx_irq;
    assign source_vec[8]   = timer0_irq;
    assign source_vec[9]   = timer1_irq;
    assign source_vec[10]  = state.flag;
    assign source_vec[11]  = peer_dma_done;

    assign count_less = state.cnt - dai_pkg::COUNT_ONE;

    generate
        for (genvar i = 0; i < dai_pkg::SRC_N; i++) begin : g_gate
            localparam int CPOS  = TWO_CHANNEL ? dai_pkg::CPU_POS_TWO[i]
                                               : dai_pkg::CPU_POS_ONE[i];
            localparam int D0POS = TWO_CHANNEL ? dai_pkg::DMA0_POS_TWO[i]
                                               : dai_pkg::DMA0_POS_ONE[i];
            localparam int D1POS = TWO_CHANNEL ? dai_pkg::DMA1_POS_TWO[i]
                                               : dai_pkg::DMA1_POS_ONE[i];
            if (CPOS >= 0) begin : g_cpu
                assign cpu_pass[i] = source_vec[i] & state.gate[CPOS];
            end else begin : g_cpu_none
                assign cpu_pass[i] = 1'b0;
            end
            if (D0POS >= 0) begin : g_dma0
                assign dma0_pass[i] = source_vec[i] & state.gate[D0POS];
            end else begin : g_dma0_none
                assign dma0_pass[i] = 1'b0;
            end
            if (D1POS >= 0) begin : g_dma1
                assign dma1_pass[i] = source_vec[i] & state.gate[D1POS];
            end else begin : g_dma1_none
                assign dma1_pass[i] = 1'b0;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_state = state;

        // Pointer stepping; a software load in the same cycle takes precedence.
        if (read_done) begin
            next_state.src = dai_step(state.src, source_step_up, source_step_down);
        end
        if (write_done) begin
            next_state.dst = dai_step(state.dst, dest_step_up, dest_step_down);
        end
        if (source_load) begin
            next_state.src = reg_wdata[23:0];
        end
        if (dest_load) begin
            next_state.dst = reg_wdata[23:0];
        end

        // The end of a pending last write is seen before a new write start is
        // handled, so back-to-back transfers cannot lose the completion. A set in
        // the same cycle as a software clear wins, so no completion is dropped.
        case (state.phase)
            ph_idle: begin
                if (dma_irq_clear) begin
                    next_state.flag = 1'b0;
                end
            end
            ph_last_write: begin
                if (write_done) begin
                    next_state.flag  = 1'b1;
                    next_state.phase = ph_idle;
                end else if (dma_irq_clear) begin
                    next_state.flag = 1'b0;
                end
            end
            default: begin
                next_state.phase = ph_idle;
            end
        endcase

        if (write_start) begin
            next_state.cnt  = count_less;
            next_state.zero = (count_less == dai_pkg::COUNT_RST);
            if (count_less == dai_pkg::COUNT_RST && count_zero_irq_on) begin
                next_state.phase = ph_last_write;
            end
        end
        if (count_load) begin
            next_state.cnt  = reg_wdata[23:0];
            next_state.zero = 1'b0;
        end

        if (gate_load) begin
            next_state.gate = reg_wdata & GATE_WMASK;
        end

        next_state.cpu_out  = cpu_pass;
        next_state.dma0_out = dma0_pass;
        next_state.dma1_out = dma1_pass;
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state.src      <= dai_pkg::POINTER_RST;
            state.dst      <= dai_pkg::POINTER_RST;
            state.cnt      <= dai_pkg::COUNT_RST;
            state.gate     <= dai_pkg::GATE_RST;
            state.phase    <= ph_idle;
            state.flag     <= 1'b0;
            state.zero     <= 1'b0;
            state.cpu_out  <= 12'h000;
            state.dma0_out <= 12'h000;
            state.dma1_out <= 12'h000;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////

    assign dma_source_pointer      = state.src;
    assign dma_destination_pointer = state.dst;
    assign dma_word_countdown      = state.cnt;
    assign cpu_dma_interrupt_gate  = state.gate;
    assign dma_irq_flag            = state.flag;
    assign count_at_zero           = state.zero;
    assign cpu_irq_gated           = state.cpu_out;
    assign dma0_sync_gated         = state.dma0_out;
    assign dma1_sync_gated         = state.dma1_out;

endmodule : dai_channel
`default_nettype wire

//--- dai_channel_props.sv
`timescale 1ns/1ps
`default_nettype none
module dai_channel_chk #(
    parameter bit TWO_CHANNEL = 1'b0
) (
    // Clock, reset and controls
    input wire logic        clk_sys, sys_rst, source_load, dest_load, count_load,
    input wire logic        source_step_up, source_step_down, dest_step_up, dest_step_down,
    input wire logic        read_done, write_start, write_done, timer0_irq,
    // Observed state
    input wire logic [23:0] dma_source_pointer, dma_destination_pointer, dma_word_countdown,
    input wire logic [31:0] cpu_dma_interrupt_gate,
    input wire logic        dma_irq_flag, count_at_zero,
    input wire logic [11:0] cpu_irq_gated
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    localparam logic [31:0] WMASK = TWO_CHANNEL ? dai_pkg::GATE_WMASK_TWO : dai_pkg::GATE_WMASK_ONE;
    ////////////////////////////////////////////////////////////////////////////
    AST_SRC_UP: assert property (read_done && source_step_up && !source_step_down
        && !source_load |=> dma_source_pointer == $past(dma_source_pointer) + 24'h000001)
        else $error("source pointer did not step up");
    AST_SRC_DN: assert property (read_done && !source_step_up && source_step_down
        && !source_load |=> dma_source_pointer == $past(dma_source_pointer) - 24'h000001)
        else $error("source pointer did not step down");
    AST_DST_HOLD: assert property (write_done && dest_step_up && dest_step_down
        && !dest_load |=> $stable(dma_destination_pointer)) else $error("destination moved");
    AST_CNT_DEC: assert property (write_start && !count_load
        |=> dma_word_countdown == $past(dma_word_countdown) - 24'h000001)
        else $error("countdown did not drop by one");
    AST_CNT_ZERO: assert property (write_start && !count_load
        && dma_word_countdown == 24'h000001 |=> count_at_zero) else $error("zero not seen");
    AST_GATE_RSVD: assert property ((cpu_dma_interrupt_gate & ~WMASK) == 32'h00000000)
        else $error("reserved gate bit set");
    // Timer 0 sits at gate bit 8 in both layouts, so this holds for either one.
    AST_GATE_PASS: assert property (1'b1 |=> cpu_irq_gated[8] ==
        $past(cpu_dma_interrupt_gate[8] & timer0_irq)) else $error("timer gating wrong");
    AST_FLAG_LAST: assert property ($rose(dma_irq_flag) |-> $past(write_done))
        else $error("flag rose without a finished write");
    cover property ($rose(dma_irq_flag));
    cover property (write_start && dma_word_countdown == 24'h000000);
    cover property (read_done && source_step_down);
endmodule : dai_channel_chk
bind dai_channel dai_channel_chk #(.TWO_CHANNEL(TWO_CHANNEL)) chk (.*);
`default_nettype wire

//--- dai_pkg.sv
// Functional notes
// - Channel holds 24-bit source and destination pointers, both cleared by reset.
// - Read completion steps source, write completion steps destination, per up/down bits.
// - A 24-bit word countdown holds words to move, cleared by reset.
// - Countdown drops by one when a write starts, after destination fetch.
// - With count_zero_irq_on set, reaching zero sets the channel DMA flag.
// - Flag rises only after the decrement and after the final write finishes.
// - Zero is tested after the decrement, so a count of one moves one word.
// - Countdown is unsigned and wraps below zero; start of zero moves the maximum.
// - Interrupt gate is 32 bits, CPU enables low, DMA enables high.
// - A one in a gate bit passes its source, a zero blocks it.
// - Reset clears every gate bit.
// - Unused gate positions always read zero.
// - Single channel CPU half: ext 0-3, serial0, serial1, timers, DMA at 0-10.
// - Single channel DMA half: bits 16-26 gate the same sources in order.
// - Two channel CPU half: ext, serial tx/rx, timers at 8-9, DMA done 10-11.
// - Two channel DMA half: ch0 ext at 16-19, ch1 ext at 28-31, own timer/serial.
// - Two channel: bit 26 lets ch1 done trigger ch0, bit 27 the reverse.
`default_nettype none
package dai_pkg;

    localparam int ADDR_W = 24;
    localparam int GATE_W = 32;
    localparam int SRC_N  = 12;

    localparam logic [23:0] POINTER_RST = 24'h000000;
    localparam logic [23:0] COUNT_RST   = 24'h000000;
    localparam logic [23:0] COUNT_ONE   = 24'h000001;
    localparam logic [31:0] GATE_RST    = 32'h00000000;

    // Bits that software can set; everything else stays zero.
    localparam logic [31:0] GATE_WMASK_ONE = 32'h07FF07FF;
    localparam logic [31:0] GATE_WMASK_TWO = 32'hFFFF0F3F;

    // Source order: ext0..3, s0tx, s0rx, s1tx, s1rx, tmr0, tmr1, dma0 done, dma1 done.
    // A position of -1 means the source has no gate bit in that layout.
    localparam int CPU_POS_ONE  [SRC_N] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, -1};
    localparam int DMA0_POS_ONE [SRC_N] = '{16, 17, 18, 19, 20, 21, 22, 23, 24, 25, 26, -1};
    localparam int DMA1_POS_ONE [SRC_N] = '{-1, -1, -1, -1, -1, -1, -1, -1, -1, -1, -1, -1};
    localparam int CPU_POS_TWO  [SRC_N] = '{0, 1, 2, 3, 4, 5, -1, -1, 8, 9, 10, 11};
    localparam int DMA0_POS_TWO [SRC_N] = '{16, 17, 18, 19, 20, -1, -1, -1, 24, 25, -1, 26};
    localparam int DMA1_POS_TWO [SRC_N] = '{28, 29, 30, 31, -1, 21, -1, -1, 22, 23, 27, -1};

endpackage : dai_pkg
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
    logic clk_sys, sys_rst, source_load, dest_load, count_load, gate_load, go, slow;
    logic source_step_up, source_step_down, dest_step_up, dest_step_down;
    logic count_zero_irq_on, dma_irq_clear, read_done, write_start, write_done, busy;
    logic dma_irq_flag, count_at_zero;
    logic [31:0] reg_wdata, cpu_dma_interrupt_gate;
    logic [23:0] dma_source_pointer, dma_destination_pointer, dma_word_countdown;
    logic [11:0] src, cpu_irq_gated, dma0_sync_gated, dma1_sync_gated;
    logic [31:0] g2;
    logic [11:0] c2, d02, d12;
    int n_mismatch = 0;
    int checks = 0;
    dai_channel #(.TWO_CHANNEL(1'b0)) uut (.*, .ext_irq(src[3:0]), .serial0_tx_irq(src[4]),
        .serial0_rx_irq(src[5]), .serial1_tx_irq(src[6]), .serial1_rx_irq(src[7]),
        .timer0_irq(src[8]), .timer1_irq(src[9]), .peer_dma_done(src[11]));
    // The two-channel layout shares every input with the single-channel instance.
    dai_channel #(.TWO_CHANNEL(1'b1)) uut2 (.*, .ext_irq(src[3:0]), .serial0_tx_irq(src[4]),
        .serial0_rx_irq(src[5]), .serial1_tx_irq(src[6]), .serial1_rx_irq(src[7]),
        .timer0_irq(src[8]), .timer1_irq(src[9]), .peer_dma_done(src[11]),
        .dma_source_pointer(), .dma_destination_pointer(), .dma_word_countdown(),
        .cpu_dma_interrupt_gate(g2), .dma_irq_flag(), .count_at_zero(),
        .cpu_irq_gated(c2), .dma0_sync_gated(d02), .dma1_sync_gated(d12));
    dai_bus_model pm (.*);
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("mismatches=%0d checks=%0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    task automatic ld(input int sel, input logic [31:0] d);
        reg_wdata = d;
        {source_load, dest_load, count_load, gate_load} = 4'h8 >> sel;
        @(negedge clk_sys);
        {source_load, dest_load, count_load, gate_load} = 4'h0;
    endtask : ld
    task automatic word();
        go = 1'b1;
        @(negedge clk_sys);
        go = 1'b0;
        for (int i = 0; i < 20 && busy; i++) @(negedge clk_sys);
        if (busy !== 1'b0) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask : word
    task automatic zchk();
        `CHK({dma_source_pointer, dma_destination_pointer, dma_word_countdown}, 72'h0)
        `CHK({cpu_dma_interrupt_gate, dma_irq_flag}, 33'h000000000)
    endtask : zchk
    initial begin
        {sys_rst, source_load, dest_load, count_load, gate_load, go, slow} = 7'h40;
        {source_step_up, source_step_down, dest_step_up, dest_step_down} = 4'h0;
        {count_zero_irq_on, dma_irq_clear, reg_wdata, src} = 46'h0;
        repeat (20) @(negedge clk_sys);
        sys_rst = 1'b0;
        zchk();
        ld(3, 32'hFFFFFFFF);
        `CHK(cpu_dma_interrupt_gate, 32'h07FF07FF)
        `CHK(g2, 32'hFFFF0F3F)
        for (int i = 0; i < 12; i++) begin
            src = 12'h001 << i;
            repeat (2) @(negedge clk_sys);
            `CHK({cpu_irq_gated, dma0_sync_gated, dma1_sync_gated}, (i < 10) ? {src, src, 12'h000} : 36'h000000000)
            `CHK({c2, d02, d12}, {src & 12'hB3F, src & 12'hB1F, src & 12'h32F})
        end
        ld(3, 32'h00000400);
        src = 12'hFFF;
        repeat (2) @(negedge clk_sys);
        `CHK(cpu_irq_gated, 12'h000)
        `CHK({c2, d02, d12}, 36'h000000000)
        ld(0, 32'h00FFFFFF);
        ld(1, 32'h00000000);
        ld(2, 32'h00000001);
        {source_step_up, dest_step_down, count_zero_irq_on, slow} = 4'hF;
        word();
        `CHK({dma_source_pointer, dma_destination_pointer}, 48'h000000FFFFFF)
        `CHK({dma_word_countdown, count_at_zero, dma_irq_flag}, 26'h0000003)
        @(negedge clk_sys);
        `CHK(cpu_irq_gated[10], 1'b1)
        dma_irq_clear = 1'b1;
        @(negedge clk_sys);
        dma_irq_clear = 1'b0;
        `CHK(dma_irq_flag, 1'b0)
        // A zero start must wrap to the top rather than stop, and both step bits mean hold.
        ld(2, 32'h00000000);
        {source_step_up, source_step_down, dest_step_up, dest_step_down, slow} = 5'h1E;
        word();
        `CHK({dma_source_pointer, dma_destination_pointer}, 48'h000000FFFFFF)
        `CHK({dma_word_countdown, dma_irq_flag}, 25'h1FFFFFE)
        {source_step_up, source_step_down} = 2'h1;
        word();
        `CHK(dma_source_pointer, 24'hFFFFFF)
        sys_rst = 1'b1;
        @(negedge clk_sys);
        sys_rst = 1'b0;
        zchk();
        `CHK(g2, 32'h00000000)
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
